// File: pkg/pdd_pkg.sv
package pdd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int          PDD_PINS   = 8;
    localparam int          PDD_ADDR_W = 8;
    localparam int          PDD_DATA_W = 32;
    localparam int          PDD_ISC_W  = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [5:0]  IDX_DRIVE_ENABLE        = 6'h00;
    localparam logic [5:0]  IDX_DRIVE_ENABLE_SET    = 6'h01;
    localparam logic [5:0]  IDX_DRIVE_ENABLE_CLEAR  = 6'h02;
    localparam logic [5:0]  IDX_DRIVE_ENABLE_TOGGLE = 6'h03;
    localparam logic [5:0]  IDX_DRIVE_LEVEL         = 6'h04;
    localparam logic [5:0]  IDX_DRIVE_LEVEL_SET     = 6'h05;
    localparam logic [5:0]  IDX_DRIVE_LEVEL_CLEAR   = 6'h06;
    localparam logic [5:0]  IDX_DRIVE_LEVEL_TOGGLE  = 6'h07;
    localparam logic [5:0]  IDX_PIN_CTRL_FIRST      = 6'h10;
    localparam logic [5:0]  IDX_PIN_CTRL_LAST       = 6'h17;
    localparam logic [1:0]  ADDR_WORD_OFFSET        = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and codes
    localparam int          ISC_LSB           = 0;
    localparam logic [2:0]  ISC_INPUT_DISABLE = 3'h4;
    localparam int          STRB_LOW_LANE     = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0]  RST_DRIVE_ENABLE = 8'h00;
    localparam logic [7:0]  RST_DRIVE_LEVEL  = 8'h00;
    localparam logic [2:0]  RST_ISC          = 3'h0;
    localparam logic [31:0] RDATA_NONE       = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        PDD_OP_NONE  = 3'b000,
        PDD_OP_WRITE = 3'b001,
        PDD_OP_SET   = 3'b010,
        PDD_OP_CLR   = 3'b011,
        PDD_OP_TGL   = 3'b100
    } pdd_op_t;

    typedef struct packed {
        logic [PDD_PINS-1:0] level;
        logic [PDD_PINS-1:0] oeN;
    } pdd_pins_t;

endpackage

// File: rtl/pdd_strobe_merge.sv
`timescale 1ns/1ps

module pdd_strobe_merge
    import pdd_pkg::*;
(
    input  wire logic [PDD_PINS-1:0] cur,
    input  wire logic [PDD_PINS-1:0] wdata,
    input  wire pdd_op_t             op,
    output logic      [PDD_PINS-1:0] nxt
);

    ////////////////////////////////////////////////////////////////////////////
    // Per-bit update from plain write or set, clear and toggle strobes
    for (genvar n = 0; n < PDD_PINS; n++) begin : g_bit
        always_comb begin
            case (op)
                PDD_OP_WRITE: nxt[n] = wdata[n];
                PDD_OP_SET:   nxt[n] = cur[n] | wdata[n];
                PDD_OP_CLR:   nxt[n] = cur[n] & ~wdata[n];
                PDD_OP_TGL:   nxt[n] = cur[n] ^ wdata[n];
                default:      nxt[n] = cur[n];
            endcase
        end
    end

endmodule

// File: rtl/pdd_sense_decode.sv
`timescale 1ns/1ps

module pdd_sense_decode
    import pdd_pkg::*;
(
    input  wire logic [PDD_PINS-1:0][PDD_ISC_W-1:0] input_sense_config,
    output logic      [PDD_PINS-1:0]                bufEn
);

    ////////////////////////////////////////////////////////////////////////////
    // Input buffer is off only for the input-disable code
    for (genvar n = 0; n < PDD_PINS; n++) begin : g_pin
        assign bufEn[n] = (input_sense_config[n] != ISC_INPUT_DISABLE);
    end

endmodule

// File: rtl/pdd_port_drive.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps

// How it works
// (RL1) A drive-enable bit of 0 turns the pin driver off, 1 turns it on.
// (RL2) Drive-enable never touches the input buffer; only the input sense field does.
// (RL3) Writing ones to drive_enable_set (index 0x01) sets those drive-enable bits.
// (RL4) Writing ones to drive_enable_clear (index 0x02) clears those drive-enable bits.
// (RL5) Writing ones to drive_enable_toggle (index 0x03) inverts those drive-enable bits.
// (RL6) Reads of the enable set, clear and toggle registers return drive-enable.
// (RL7) A drive-level bit of 0 drives the pin low and 1 drives it high.
// (RL8) The drive level reaches the pin only while its driver is enabled.
// (RL9) drive_level is an 8-bit read/write register at index 0x04, reset 0x00.
// (RL10) Writing ones to drive_level_set (index 0x05) sets those level bits.
// (RL11) Writing ones to drive_level_clear (index 0x06) clears those level bits.
// (RL12) Reads of the level set and clear registers return drive-level.
// (RL13) Writing ones to drive_level_toggle (index 0x07) inverts those level bits.
// (RL14) Input sense code 0x4 disables the input buffer; other codes keep it on.
// (RL15) Strobe registers hold nothing; the target updates on the accepting edge.

module pdd_port_drive
    import pdd_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [PDD_ADDR_W-1:0] paddr,
    input  wire logic [PDD_DATA_W-1:0] pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [PDD_DATA_W-1:0] prdata,
    output logic                       pready,
    output logic                       pslverr,
    output pdd_pins_t                  pins,
    output logic      [PDD_PINS-1:0]   inputBufEn
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [PDD_PINS-1:0]                driveEnable;
    logic [PDD_PINS-1:0]                driveLevel;
    logic [PDD_PINS-1:0][PDD_ISC_W-1:0] input_sense_config;
    logic [PDD_PINS-1:0]                next_driveEnable;
    logic [PDD_PINS-1:0]                next_driveLevel;
    logic [PDD_PINS-1:0][PDD_ISC_W-1:0] next_isc;
    logic [PDD_PINS-1:0]                next_inputBufEn;
    pdd_pins_t                          next_pins;
    logic [PDD_DATA_W-1:0]              next_prdata;
    logic                               next_pready;
    logic                               next_pslverr;

    // Decode helpers
    logic                               wordAligned;
    logic [5:0]                         regIdx;
    logic                               isPinCtrl;
    logic [2:0]                         pinSel;
    logic                               mapped;
    logic                               wrAccept;
    pdd_op_t                            enableOp;
    pdd_op_t                            levelOp;
    logic [PDD_DATA_W-1:0]              readMux;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    assign wordAligned = (paddr[1:0] == ADDR_WORD_OFFSET);
    assign regIdx      = paddr[7:2];
    assign isPinCtrl   = (regIdx >= IDX_PIN_CTRL_FIRST) && (regIdx <= IDX_PIN_CTRL_LAST);
    assign pinSel      = regIdx[2:0];
    assign mapped      = wordAligned && (isPinCtrl || (regIdx <= IDX_DRIVE_LEVEL_TOGGLE));

    // Write taken only at the completing access edge, low byte lane enabled
    assign wrAccept = psel && penable && pready && pwrite && mapped && pstrb[STRB_LOW_LANE];

    ////////////////////////////////////////////////////////////////////////////
    // Strobe operation select for the two pin registers
    always_comb begin
        enableOp = PDD_OP_NONE;
        levelOp  = PDD_OP_NONE;
        if (wrAccept) begin
            case (regIdx)
                IDX_DRIVE_ENABLE:        enableOp = PDD_OP_WRITE;
                IDX_DRIVE_ENABLE_SET:    enableOp = PDD_OP_SET; // RL3
                IDX_DRIVE_ENABLE_CLEAR:  enableOp = PDD_OP_CLR; // RL4
                IDX_DRIVE_ENABLE_TOGGLE: enableOp = PDD_OP_TGL; // RL5
                IDX_DRIVE_LEVEL:         levelOp  = PDD_OP_WRITE; // RL9
                IDX_DRIVE_LEVEL_SET:     levelOp  = PDD_OP_SET; // RL10
                IDX_DRIVE_LEVEL_CLEAR:   levelOp  = PDD_OP_CLR; // RL11
                IDX_DRIVE_LEVEL_TOGGLE:  levelOp  = PDD_OP_TGL; // RL13
                default: begin
                    enableOp = PDD_OP_NONE;
                    levelOp  = PDD_OP_NONE;
                end
            endcase
        end
    end

    // Bit merge for drive-enable; strobes keep no copy of their own
    pdd_strobe_merge u_enable_merge (
        .cur   (driveEnable),
        .wdata (pwdata[PDD_PINS-1:0]),
        .op    (enableOp),
        .nxt   (next_driveEnable)
    ); // RL15

    // Bit merge for drive-level
    pdd_strobe_merge u_level_merge (
        .cur   (driveLevel),
        .wdata (pwdata[PDD_PINS-1:0]),
        .op    (levelOp),
        .nxt   (next_driveLevel)
    ); // RL15

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin input sense field update
    always_comb begin
        next_isc = input_sense_config;
        if (wrAccept && isPinCtrl) begin
            next_isc[pinSel] = pwdata[ISC_LSB +: PDD_ISC_W];
        end
    end

    // Input buffer enable follows the sense field alone
    pdd_sense_decode u_sense (
        .input_sense_config   (next_isc),
        .bufEn (next_inputBufEn)
    ); // RL2 RL14

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive: enable low on the oe pin while driving, level straight out
    always_comb begin
        next_pins.oeN   = ~next_driveEnable; // RL1 RL8
        next_pins.level = next_driveLevel;   // RL7
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; companions show the underlying register
    always_comb begin
        readMux = RDATA_NONE;
        if (isPinCtrl) begin
            readMux[ISC_LSB +: PDD_ISC_W] = input_sense_config[pinSel];
        end else begin
            case (regIdx)
                IDX_DRIVE_ENABLE,
                IDX_DRIVE_ENABLE_SET,
                IDX_DRIVE_ENABLE_CLEAR,
                IDX_DRIVE_ENABLE_TOGGLE: readMux[PDD_PINS-1:0] = driveEnable; // RL6
                IDX_DRIVE_LEVEL,
                IDX_DRIVE_LEVEL_SET,
                IDX_DRIVE_LEVEL_CLEAR,
                IDX_DRIVE_LEVEL_TOGGLE:  readMux[PDD_PINS-1:0] = driveLevel; // RL12
                default:                 readMux = RDATA_NONE;
            endcase
        end
        if (!mapped) begin
            readMux = RDATA_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: no wait state, ready and data registered in setup
    always_comb begin
        next_pready  = psel && !penable;
        next_pslverr = psel && !penable && !mapped;
        next_prdata  = prdata;
        if (psel && !penable) begin
            next_prdata = pwrite ? RDATA_NONE : readMux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk) begin
        if (srst) begin
            driveEnable <= RST_DRIVE_ENABLE;
            driveLevel  <= RST_DRIVE_LEVEL; // RL9
            input_sense_config         <= {PDD_PINS{RST_ISC}};
            inputBufEn  <= {PDD_PINS{1'b1}};
            pins.oeN    <= ~RST_DRIVE_ENABLE;
            pins.level  <= RST_DRIVE_LEVEL;
            prdata      <= RDATA_NONE;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
        end else begin
            driveEnable <= next_driveEnable;
            driveLevel  <= next_driveLevel;
            input_sense_config         <= next_isc;
            inputBufEn  <= next_inputBufEn;
            pins        <= next_pins;
            prdata      <= next_prdata;
            pready      <= next_pready;
            pslverr     <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertion helpers
    logic                wrEnable;
    logic                wrLevel;
    logic [PDD_PINS-1:0] wrData;
    assign wrEnable = wrAccept && !isPinCtrl && (regIdx <= IDX_DRIVE_ENABLE_TOGGLE);
    assign wrLevel  = wrAccept && !isPinCtrl && (regIdx >= IDX_DRIVE_LEVEL);
    assign wrData   = pwdata[PDD_PINS-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    AST_DRIVER_OFF: assert property (@(posedge clk) disable iff (srst) // RL1
        pins.oeN == ~driveEnable)
        else $error("pin driver enable does not follow drive-enable");

    AST_BUF_INDEPENDENT: assert property (@(posedge clk) disable iff (srst) // RL2
        !(wrAccept && isPinCtrl) |=> $stable(inputBufEn))
        else $error("input buffer changed without a sense field write");

    AST_ENABLE_SET: assert property (@(posedge clk) disable iff (srst) // RL3
        (wrAccept && regIdx == IDX_DRIVE_ENABLE_SET)
        |=> driveEnable == ($past(driveEnable) | $past(wrData)))
        else $error("drive-enable set strobe gave wrong value");

    AST_ENABLE_CLEAR: assert property (@(posedge clk) disable iff (srst) // RL4
        (wrAccept && regIdx == IDX_DRIVE_ENABLE_CLEAR)
        |=> driveEnable == ($past(driveEnable) & ~$past(wrData)))
        else $error("drive-enable clear strobe gave wrong value");

    AST_ENABLE_TOGGLE: assert property (@(posedge clk) disable iff (srst) // RL5
        (wrAccept && regIdx == IDX_DRIVE_ENABLE_TOGGLE)
        |=> driveEnable == ($past(driveEnable) ^ $past(wrData)))
        else $error("drive-enable toggle strobe gave wrong value");

    AST_READ_ENABLE: assert property (@(posedge clk) disable iff (srst) // RL6
        (psel && !penable && !pwrite && wordAligned && regIdx >= IDX_DRIVE_ENABLE_SET
         && regIdx <= IDX_DRIVE_ENABLE_TOGGLE)
        |=> pready && prdata == {24'h000000, driveEnable})
        else $error("enable companion read did not return drive-enable");

    AST_LEVEL_OUT: assert property (@(posedge clk) disable iff (srst) // RL7
        pins.level == driveLevel)
        else $error("pin level does not follow drive-level");

    AST_LEVEL_GATED: assert property (@(posedge clk) disable iff (srst) // RL8
        !driveEnable[0] |-> pins.oeN[0])
        else $error("pin 0 driven while its driver is disabled");

    AST_LEVEL_RESET: assert property (@(posedge clk) // RL9
        srst |=> driveLevel == RST_DRIVE_LEVEL && driveEnable == RST_DRIVE_ENABLE)
        else $error("pin registers not cleared by reset");

    AST_LEVEL_SET: assert property (@(posedge clk) disable iff (srst) // RL10
        (wrAccept && regIdx == IDX_DRIVE_LEVEL_SET)
        |=> driveLevel == ($past(driveLevel) | $past(wrData)))
        else $error("drive-level set strobe gave wrong value");

    AST_LEVEL_CLEAR: assert property (@(posedge clk) disable iff (srst) // RL11
        (wrAccept && regIdx == IDX_DRIVE_LEVEL_CLEAR)
        |=> driveLevel == ($past(driveLevel) & ~$past(wrData)))
        else $error("drive-level clear strobe gave wrong value");

    AST_READ_LEVEL: assert property (@(posedge clk) disable iff (srst) // RL12
        (psel && !penable && !pwrite && wordAligned
         && (regIdx == IDX_DRIVE_LEVEL_SET || regIdx == IDX_DRIVE_LEVEL_CLEAR))
        |=> prdata == {24'h000000, driveLevel})
        else $error("level companion read did not return drive-level");

    AST_LEVEL_TOGGLE: assert property (@(posedge clk) disable iff (srst) // RL13
        (wrAccept && regIdx == IDX_DRIVE_LEVEL_TOGGLE)
        |=> driveLevel == ($past(driveLevel) ^ $past(wrData)))
        else $error("drive-level toggle strobe gave wrong value");

    AST_BUF_DISABLE: assert property (@(posedge clk) disable iff (srst) // RL14
        inputBufEn[0] == (input_sense_config[0] != ISC_INPUT_DISABLE))
        else $error("input buffer enable wrong for pin 0 sense code");

    AST_NO_STRAY_WRITE: assert property (@(posedge clk) disable iff (srst) // RL15
        !wrEnable |=> $stable(driveEnable))
        else $error("drive-enable changed without an accepted write");

    AST_LEVEL_HOLD: assert property (@(posedge clk) disable iff (srst) // RL15
        !wrLevel |=> $stable(driveLevel))
        else $error("drive-level changed without an accepted write");

    AST_READY_TIMING: assert property (@(posedge clk) disable iff (srst)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");

    AST_ERR_UNMAPPED: assert property (@(posedge clk) disable iff (srst)
        (psel && !penable && !mapped) |=> pready && pslverr)
        else $error("unmapped access did not answer with an error");

    AST_NO_ERR_MAPPED: assert property (@(posedge clk) disable iff (srst)
        (psel && !penable && mapped) |=> !pslverr)
        else $error("mapped access answered with an error");

    AST_ERR_WITH_READY: assert property (@(posedge clk) disable iff (srst)
        pslverr |-> pready)
        else $error("error response outside the access cycle");

    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (srst)
        (psel && !penable && !pwrite && !mapped) |=> prdata == RDATA_NONE)
        else $error("unmapped read returned nonzero data");

    AST_WRITE_NO_DATA: assert property (@(posedge clk) disable iff (srst)
        (psel && !penable && pwrite) |=> prdata == RDATA_NONE)
        else $error("write answered with nonzero read data");

    AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (srst) // RL1
        (wrAccept && regIdx == IDX_DRIVE_ENABLE)
        |=> driveEnable == $past(wrData))
        else $error("drive-enable plain write gave wrong value");

    AST_LEVEL_WRITE: assert property (@(posedge clk) disable iff (srst) // RL9
        (wrAccept && regIdx == IDX_DRIVE_LEVEL)
        |=> driveLevel == $past(wrData))
        else $error("drive-level plain write gave wrong value");

    AST_SENSE_WRITE: assert property (@(posedge clk) disable iff (srst) // RL14
        (wrAccept && isPinCtrl)
        |=> input_sense_config[$past(pinSel)] == $past(pwdata[ISC_LSB +: PDD_ISC_W]))
        else $error("sense field write gave wrong value");

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin checks of driver gating and input buffer decode
    for (genvar n = 0; n < PDD_PINS; n++) begin : g_pin_chk
        AST_PIN_GATED: assert property (@(posedge clk) disable iff (srst) // RL8
            !driveEnable[n] |-> pins.oeN[n])
            else $error("pin driven while its driver is disabled");

        AST_PIN_BUF: assert property (@(posedge clk) disable iff (srst) // RL2 RL14
            inputBufEn[n] == (input_sense_config[n] != ISC_INPUT_DISABLE))
            else $error("input buffer enable does not match its sense code");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cover scenarios
    CVR_ENABLE_TOGGLE: cover property (@(posedge clk) disable iff (srst)
        wrAccept && regIdx == IDX_DRIVE_ENABLE_TOGGLE && wrData != 8'h00);

    CVR_LEVEL_SET_THEN_CLEAR: cover property (@(posedge clk) disable iff (srst)
        (wrAccept && regIdx == IDX_DRIVE_LEVEL_SET) ##[1:8]
        (wrAccept && regIdx == IDX_DRIVE_LEVEL_CLEAR));

    CVR_BUF_OFF: cover property (@(posedge clk) disable iff (srst)
        inputBufEn != 8'hFF);

    CVR_UNMAPPED: cover property (@(posedge clk) disable iff (srst)
        pready && pslverr);

    CVR_PIN_DRIVEN_HIGH: cover property (@(posedge clk) disable iff (srst)
        !pins.oeN[0] && pins.level[0]);

endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps

module tb_top
    import pdd_pkg::*;
    ;

    typedef struct {
        logic [5:0] idx;
        logic [7:0] wd;
        logic [7:0] de;
        logic [7:0] lv;
    } pdd_row_t;

    logic                  clk;
    logic                  srst;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [PDD_ADDR_W-1:0] paddr;
    logic [PDD_DATA_W-1:0] pwdata;
    logic [3:0]            pstrb;
    logic [PDD_DATA_W-1:0] prdata;
    logic                  pready;
    logic                  pslverr;
    pdd_pins_t             pins;
    logic [PDD_PINS-1:0]   inputBufEn;
    logic [31:0]           rdData;
    logic                  rdErr;
    int                    errors;
    int                    total_checks;

    // Ordinary cases: index, write data, then expected enable and level after it
    pdd_row_t rows [12] = '{
        '{6'h00, 8'h5A, 8'h5A, 8'h00},
        '{6'h01, 8'h81, 8'hDB, 8'h00},
        '{6'h02, 8'h0F, 8'hD0, 8'h00},
        '{6'h03, 8'hFF, 8'h2F, 8'h00},
        '{6'h01, 8'h00, 8'h2F, 8'h00},
        '{6'h04, 8'h3C, 8'h2F, 8'h3C},
        '{6'h05, 8'hC0, 8'h2F, 8'hFC},
        '{6'h06, 8'h14, 8'h2F, 8'hE8},
        '{6'h07, 8'h0F, 8'h2F, 8'hE7},
        '{6'h07, 8'h00, 8'h2F, 8'hE7},
        '{6'h02, 8'h00, 8'h2F, 8'hE7},
        '{6'h03, 8'h00, 8'h2F, 8'hE7}
    };

    ////////////////////////////////////////////////////////////////////////////
    // Device under test
    pdd_port_drive dut (
        .clk        (clk),
        .srst       (srst),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .pstrb      (pstrb),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .pins       (pins),
        .inputBufEn (inputBufEn)
    );

    // Free-running clock, 50 ns period
    always #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // Closing report, also used when a wait runs out
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Compare one value, counting every compare
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] rd, output logic er);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            $display("[ERR] pready expected 1 seen %b", pready);
            give_verdict();
        end else begin
            rd = prdata;
            er = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Pin outputs after a settled edge
    task automatic chk_pins(input logic [7:0] de, input logic [7:0] lv);
        #1;
        chk("oeN", {24'h000000, ~de}, {24'h000000, pins.oeN});
        chk("level", {24'h000000, lv}, {24'h000000, pins.level});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk     = 1'b0;
        srst    = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h00000000;
        pstrb   = 4'hF;
        errors  = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        // Reset values
        chk_pins(8'h00, 8'h00);
        chk("bufEn", 32'h000000FF, {24'h000000, inputBufEn});
        apb(1'b0, 8'h10, 32'h0, 4'hF, rdData, rdErr);
        chk("levelReset", 32'h00000000, rdData);
        // Table of single writes, each followed by pins and read-back
        for (int i = 0; i < 12; i++) begin
            apb(1'b1, {rows[i].idx, 2'h0}, {24'h0, rows[i].wd}, 4'hF, rdData, rdErr);
            chk("errTable", 32'h00000000, {31'h0, rdErr});
            chk_pins(rows[i].de, rows[i].lv);
            apb(1'b0, {rows[i].idx, 2'h0}, 32'h0, 4'hF, rdData, rdErr);
            chk("readBack", {24'h0, (rows[i].idx < 6'h04) ? rows[i].de : rows[i].lv}, rdData);
        end
        // Every sense code, code n on pin n
        for (int n = 0; n < 8; n++) begin
            apb(1'b1, {6'h10 + 6'(n), 2'h0}, 32'(n), 4'hF, rdData, rdErr);
        end
        #1;
        chk("bufEnCodes", 32'h000000EF, {24'h000000, inputBufEn});
        apb(1'b0, 8'h50, 32'h0, 4'hF, rdData, rdErr);
        chk("senseRead", 32'h00000004, rdData);
        // Enable changes leave the input buffers alone
        apb(1'b1, 8'h0C, 32'h000000FF, 4'hF, rdData, rdErr);
        chk_pins(8'hD0, 8'hE7);
        chk("bufEnKept", 32'h000000EF, {24'h000000, inputBufEn});
        // Unmapped, misaligned and unstrobed writes are ignored
        apb(1'b1, 8'h20, 32'h000000FF, 4'hF, rdData, rdErr);
        chk("errUnmapped", 32'h00000001, {31'h0, rdErr});
        apb(1'b1, 8'h01, 32'h000000FF, 4'hF, rdData, rdErr);
        chk("errMisaligned", 32'h00000001, {31'h0, rdErr});
        apb(1'b1, 8'h00, 32'h000000FF, 4'h0, rdData, rdErr);
        chk("errNoStrobe", 32'h00000000, {31'h0, rdErr});
        chk_pins(8'hD0, 8'hE7);
        apb(1'b0, 8'h20, 32'h0, 4'hF, rdData, rdErr);
        chk("readUnmapped", 32'h00000000, rdData);
        // Second reset in mid-run clears everything again
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        chk_pins(8'h00, 8'h00);
        chk("bufEnAfterReset", 32'h000000FF, {24'h000000, inputBufEn});
        apb(1'b0, 8'h0C, 32'h0, 4'hF, rdData, rdErr);
        chk("enableAfterReset", 32'h00000000, rdData);
        give_verdict();
    end

endmodule
